// *** src/pic_pkg.sv ***
// package of the prioritising interrupt controller: register map, field
// positions, reset values, event codes, timing counts and carrier structs.
// assumes an apb master for software and a processor core on the same clock.
// Operation
// - levels 0 to 16, level 0 ignored
// - nmi level 16, accepted when block clear
// - nmi accepted in sleep or standby
// - nmi accept-under-block bit overrides block bit
// - nmi edge detected, edge selectable
// - nmi blind at most six cycles after select
// - nmi acceptance keeps mask level
// - withdrawn level pin request held until any accept
// - mask bit write one clears held request
// - mask update option loads accepted level
// - unique event code, common handler
// - nmi and pin event codes fixed
// - module priorities 0 to 15, reset zero
// - pin priority fields in one register
// - ties resolved nmi, pins, then modules
// - vanished request gives event code zero
// - pins masked by current mask level
// - user mode masks by user level
package pic_pkg;
    localparam int          NUM_PINS       = 8;
    localparam int          NUM_PERIPH     = 8;
    localparam int          NUM_SRC        = 1 + NUM_PINS + NUM_PERIPH;
    localparam int          IDX_W          = 5;
    localparam int          PRIO_W         = 4;
    localparam int          FIRST_PIN      = 1;
    localparam int          FIRST_PERIPH   = FIRST_PIN + NUM_PINS;
    localparam int          MOD_PER_REG    = 4;

    localparam logic [7:0]  OFF_CTRL_ZERO  = 8'h00;
    localparam logic [7:0]  OFF_CTRL_ONE   = 8'h04;
    localparam logic [7:0]  OFF_MASK_SET   = 8'h08;
    localparam logic [7:0]  OFF_MASK_CLR   = 8'h0c;
    localparam logic [7:0]  OFF_PIN_PRIO   = 8'h10;
    localparam logic [7:0]  OFF_OPMODE     = 8'h14;
    localparam logic [7:0]  OFF_USER_MASK  = 8'h18;
    localparam logic [7:0]  OFF_EVENT      = 8'h1c;
    localparam logic [7:0]  OFF_MOD_FIRST  = 8'h20;
    localparam logic [7:0]  OFF_MOD_LAST   = 8'h24;

    localparam int          CTRL0_EDGE_BIT = 0;
    localparam int          CTRL0_UBLK_BIT = 1;
    localparam int          CTRL0_PIN_BIT  = 8;
    localparam int          OPMODE_MU_BIT  = 0;

    localparam logic [31:0] RST_PIN_PRIO   = 32'h0000_0000;
    localparam logic [15:0] RST_MOD_PRIO   = 16'h0000;
    localparam logic [7:0]  RST_SENSE      = 8'h00;
    localparam logic [15:0] RST_MASK       = 16'h0000;
    localparam logic [3:0]  RST_USER_MASK  = 4'h0;

    localparam logic [11:0] CODE_NMI       = 12'h1c0;
    localparam logic [11:0] CODE_PIN_BASE  = 12'h600;
    localparam logic [11:0] CODE_MOD_BASE  = 12'h700;
    localparam logic [11:0] CODE_STEP      = 12'h020;
    localparam logic [11:0] CODE_NONE      = 12'h000;
    localparam logic [4:0]  LEVEL_NMI      = 5'h10;

    localparam int          NMI_BLANK_CYC  = 6;

    typedef struct packed {
        logic       block_bit;
        logic       low_power;
        logic       user_mode;
        logic [3:0] current_mask_level;
    } pic_core_in_t;

    typedef struct packed {
        logic       req;
        logic [4:0] level;
        logic       mask_load;
        logic [3:0] mask_value;
    } pic_core_out_t;
endpackage

// *** src/pic_top.sv ***
// prioritising interrupt controller: nmi, eight request pins, module requests,
// apb register slave and the request/accept handshake to the processor core.
// assumes pins are asynchronous, module requests and core signals are on clk.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module pic_top (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic [7:0]                 paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       nmi_pin,
    input  wire logic [7:0]                 irq_pins,
    input  wire logic [7:0]                 periph_req,
    input  wire pic_pkg::pic_core_in_t      core_in,
    input  wire logic                       core_accept,
    output pic_pkg::pic_core_out_t          core_out,
    output logic      [11:0]                event_code
);
    localparam int IDX_W = pic_pkg::IDX_W;
    localparam int NSRC  = pic_pkg::NUM_SRC;

    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] pin_prio_q;
    logic [31:0] mod_prio_q;
    logic [7:0]  sense_q;
    logic [15:0] mask_q;
    logic        edge_sel_q;
    logic        ublk_q;
    logic        mu_q;
    logic [3:0]  user_mask_q;
    logic [11:0] event_q;
    logic [2:0]  nmi_sync_q;
    logic        nmi_stab_q;
    logic        nmi_prev_q;
    logic [2:0]  blank_q;
    logic        nmi_pend_q;
    logic [7:0]  pin_s1_q;
    logic [7:0]  pin_s2_q;
    logic [7:0]  pin_s3_q;
    logic [7:0]  pin_stab_q;
    logic [7:0]  pin_prev_q;
    logic [7:0]  held_q;
    logic [7:0]  relatch_q;
    logic [7:0]  own_acc;
    pic_pkg::pic_core_out_t core_q;

    logic        acc_phase;
    logic        wr_go;
    logic        mapped;
    logic        acc_go;
    logic        nmi_edge;
    logic        nmi_allow;
    logic [7:0]  pin_set;
    logic [7:0]  pin_clr;
    logic [15:0] mask_wr_ones;
    logic [4:0]  src_lvl [NSRC];
    logic        src_ok  [NSRC];
    logic        win_ok;
    logic [IDX_W-1:0] win_idx;
    logic [4:0]  win_level;

    // 4-bit priority field of pin n, pin 0 in the top nibble
    function automatic logic [3:0] pin_prio(input logic [31:0] r, input int n);
        pin_prio = r[31 - 4*n -: 4];
    endfunction

    // common gate for maskable sources
    function automatic logic maskable_ok(input logic [4:0] lvl,
                                         input pic_pkg::pic_core_in_t c,
                                         input logic [3:0] umask);
        maskable_ok = (lvl != 5'h00)
                   && !c.block_bit
                   && (lvl > {1'b0, c.current_mask_level})
                   && (!c.user_mode || (lvl > {1'b0, umask}));
    endfunction

    // event code of a source index
    function automatic logic [11:0] code_of(input logic [IDX_W-1:0] idx);
        logic [11:0] off;
        off = 12'h000;
        if (idx == '0) begin
            code_of = pic_pkg::CODE_NMI;
        end else if (int'(idx) < pic_pkg::FIRST_PERIPH) begin
            off = 12'(int'(idx) - pic_pkg::FIRST_PIN);
            code_of = 12'(pic_pkg::CODE_PIN_BASE + off * pic_pkg::CODE_STEP);
        end else begin
            off = 12'(int'(idx) - pic_pkg::FIRST_PERIPH);
            code_of = 12'(pic_pkg::CODE_MOD_BASE + off * pic_pkg::CODE_STEP);
        end
    endfunction

    // apb slave: one wait state, writes land at the edge with pready high
    assign acc_phase = psel && penable && !pready_q;
    assign wr_go     = psel && penable && pwrite && pready_q;
    assign mapped    = (paddr <= pic_pkg::OFF_MOD_LAST) && (paddr[1:0] == 2'b00);
    assign mask_wr_ones = (wr_go && paddr == pic_pkg::OFF_MASK_SET) ? pwdata[15:0] : 16'h0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc_phase;
            pslverr_q <= acc_phase && !mapped;
            prdata_q  <= 32'h0000_0000;
            if (acc_phase && !pwrite) begin
                unique case (paddr)
                    pic_pkg::OFF_CTRL_ZERO: begin
                        prdata_q[pic_pkg::CTRL0_EDGE_BIT] <= edge_sel_q;
                        prdata_q[pic_pkg::CTRL0_UBLK_BIT] <= ublk_q;
                        prdata_q[pic_pkg::CTRL0_PIN_BIT]  <= nmi_stab_q;
                    end
                    pic_pkg::OFF_CTRL_ONE:  prdata_q[7:0]  <= sense_q;
                    pic_pkg::OFF_MASK_SET,
                    pic_pkg::OFF_MASK_CLR:  prdata_q[15:0] <= mask_q;
                    pic_pkg::OFF_PIN_PRIO:  prdata_q       <= pin_prio_q;
                    pic_pkg::OFF_OPMODE:    prdata_q[pic_pkg::OPMODE_MU_BIT] <= mu_q;
                    pic_pkg::OFF_USER_MASK: prdata_q[3:0]  <= user_mask_q;
                    pic_pkg::OFF_EVENT:     prdata_q[11:0] <= event_q;
                    pic_pkg::OFF_MOD_FIRST: prdata_q[15:0] <= mod_prio_q[15:0];
                    pic_pkg::OFF_MOD_LAST:  prdata_q[15:0] <= mod_prio_q[31:16];
                    default:                prdata_q       <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software-written configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_prio_q  <= pic_pkg::RST_PIN_PRIO;
            mod_prio_q  <= {pic_pkg::RST_MOD_PRIO, pic_pkg::RST_MOD_PRIO};
            sense_q     <= pic_pkg::RST_SENSE;
            edge_sel_q  <= 1'b0;
            ublk_q      <= 1'b0;
            mu_q        <= 1'b0;
            user_mask_q <= pic_pkg::RST_USER_MASK;
        end else if (wr_go) begin
            unique case (paddr)
                pic_pkg::OFF_CTRL_ZERO: begin
                    edge_sel_q <= pwdata[pic_pkg::CTRL0_EDGE_BIT];
                    ublk_q     <= pwdata[pic_pkg::CTRL0_UBLK_BIT];
                end
                pic_pkg::OFF_CTRL_ONE:  sense_q <= pwdata[7:0];
                pic_pkg::OFF_PIN_PRIO:  pin_prio_q <= pwdata;
                pic_pkg::OFF_OPMODE:    mu_q <= pwdata[pic_pkg::OPMODE_MU_BIT];
                pic_pkg::OFF_USER_MASK: user_mask_q <= pwdata[3:0];
                pic_pkg::OFF_MOD_FIRST: mod_prio_q[15:0] <= pwdata[15:0];
                pic_pkg::OFF_MOD_LAST:  mod_prio_q[31:16] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // mask bits: set register writes ones, clear register removes them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= pic_pkg::RST_MASK;
        end else if (wr_go && paddr == pic_pkg::OFF_MASK_SET) begin
            mask_q <= mask_q | pwdata[15:0];
        end else if (wr_go && paddr == pic_pkg::OFF_MASK_CLR) begin
            mask_q <= mask_q & ~pwdata[15:0];
        end
    end

    // nmi pin: three flops, a change counts once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_sync_q <= 3'b000;
            nmi_stab_q <= 1'b0;
            nmi_prev_q <= 1'b0;
        end else begin
            nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
            if (nmi_sync_q[1] == nmi_sync_q[2]) begin
                nmi_stab_q <= nmi_sync_q[2];
            end
            nmi_prev_q <= nmi_stab_q;
        end
    end

    // edge select changes blind the detector for a short window
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blank_q <= 3'b000;
        end else if (wr_go && paddr == pic_pkg::OFF_CTRL_ZERO
                     && pwdata[pic_pkg::CTRL0_EDGE_BIT] != edge_sel_q) begin
            blank_q <= 3'(pic_pkg::NMI_BLANK_CYC);
        end else if (blank_q != 3'b000) begin
            blank_q <= blank_q - 3'b001;
        end
    end

    assign nmi_edge  = (blank_q == 3'b000)
                    && (edge_sel_q ? (nmi_stab_q && !nmi_prev_q)
                                   : (!nmi_stab_q && nmi_prev_q));
    assign nmi_allow = !core_in.block_bit
                    || core_in.low_power
                    || ublk_q;
    assign acc_go    = core_accept && core_q.req;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_pend_q <= 1'b0;
        end else begin
            nmi_pend_q <= nmi_edge
                       || (nmi_pend_q && !(acc_go && win_ok && win_idx == '0));
        end
    end

    // request pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q   <= 8'h00;
            pin_s2_q   <= 8'h00;
            pin_s3_q   <= 8'h00;
            pin_stab_q <= 8'h00;
            pin_prev_q <= 8'h00;
        end else begin
            pin_s1_q   <= irq_pins;
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_stab_q <= (pin_s2_q & pin_s3_q) | (pin_stab_q & (pin_s2_q | pin_s3_q));
            pin_prev_q <= pin_stab_q;
        end
    end

    always_comb begin
        for (int i = 0; i < pic_pkg::NUM_PINS; i++) begin
            own_acc[i] = acc_go && win_ok && int'(win_idx) == i + pic_pkg::FIRST_PIN;
            pin_set[i] = sense_q[i] ? (pin_stab_q[i] && !pin_prev_q[i])
                                    : (pin_stab_q[i] && !relatch_q[i] && !own_acc[i]);
            pin_clr[i] = mask_wr_ones[i]
                      || own_acc[i]
                      || (acc_go && !sense_q[i] && !pin_stab_q[i]);
        end
    end

    // a level pin just accepted is not latched again until it is seen low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            relatch_q <= 8'h00;
        end else begin
            relatch_q <= (relatch_q | own_acc) & pin_stab_q & ~sense_q;
        end
    end

    // a fresh event beats a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= 8'h00;
        end else begin
            held_q <= pin_set | (held_q & ~pin_clr);
        end
    end

    // source table in default order: nmi, pins 0..7, modules 0..7
    always_comb begin
        src_lvl[0] = pic_pkg::LEVEL_NMI;
        src_ok[0]  = nmi_pend_q && nmi_allow;
        for (int i = 0; i < pic_pkg::NUM_PINS; i++) begin
            src_lvl[i + pic_pkg::FIRST_PIN] = {1'b0, pin_prio(pin_prio_q, i)};
            src_ok[i + pic_pkg::FIRST_PIN]  = held_q[i] && !mask_q[i]
                && maskable_ok({1'b0, pin_prio(pin_prio_q, i)}, core_in, user_mask_q);
        end
        for (int i = 0; i < pic_pkg::NUM_PERIPH; i++) begin
            src_lvl[i + pic_pkg::FIRST_PERIPH] = {1'b0, mod_prio_q[4*i +: 4]};
            src_ok[i + pic_pkg::FIRST_PERIPH]  = periph_req[i]
                && !mask_q[i + pic_pkg::NUM_PINS]
                && maskable_ok({1'b0, mod_prio_q[4*i +: 4]}, core_in, user_mask_q);
        end
    end

    // strictly greater keeps the earlier source on a tie
    always_comb begin
        win_ok    = 1'b0;
        win_idx   = '0;
        win_level = 5'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (src_ok[i] && (!win_ok || src_lvl[i] > win_level)) begin
                win_ok    = 1'b1;
                win_idx   = IDX_W'(i);
                win_level = src_lvl[i];
            end
        end
    end

    // core handshake and event code capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_q  <= '0;
            event_q <= pic_pkg::CODE_NONE;
        end else begin
            core_q.req   <= win_ok;
            core_q.level <= win_ok ? win_level : 5'h00;
            core_q.mask_load <= acc_go && win_ok && mu_q && win_idx != '0;
            if (acc_go && win_ok && mu_q) begin
                core_q.mask_value <= win_level[3:0];
            end
            if (acc_go) begin
                event_q <= win_ok ? code_of(win_idx) : pic_pkg::CODE_NONE;
            end
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign core_out   = core_q;
    assign event_code = event_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_accept;
        core_accept && core_q.req;
    endsequence

    sequence s_nmi_won;
        s_accept ##0 (win_ok && win_idx == '0);
    endsequence

    a_zero_level_ignored: assert property (core_q.req |-> core_q.level != 5'h00)
        else $error("request presented at level zero");
    a_nmi_unblocked: assert property (nmi_pend_q && !core_in.block_bit
        |=> core_q.req && core_q.level == 5'h10)
        else $error("pending nmi not presented at level 16");
    a_nmi_low_power: assert property (nmi_pend_q && core_in.low_power
        |=> core_q.req && core_q.level == 5'h10)
        else $error("nmi not presented in low power mode");
    a_nmi_under_block: assert property (nmi_pend_q && ublk_q
        |=> core_q.req && core_q.level == 5'h10)
        else $error("nmi not presented with accept under block set");
    a_nmi_blank_ends: assert property ($rose(blank_q != 3'b000)
        |-> ##[5:6] blank_q == 3'b000)
        else $error("nmi blanking window wrong length");
    a_nmi_keep_mask: assert property (s_nmi_won |=> !core_q.mask_load)
        else $error("nmi acceptance changed the mask level");
    a_mask_update: assert property (s_accept ##0 (win_ok && mu_q && win_idx != '0)
        |=> core_q.mask_load && core_q.mask_value == $past(win_level[3:0]))
        else $error("mask level not loaded with accepted level");
    a_no_update_off: assert property (!mu_q |=> !core_q.mask_load)
        else $error("mask load while update option clear");
    a_vanished_code: assert property (s_accept ##0 !win_ok
        |=> event_q == 12'h000)
        else $error("vanished request did not give event code zero");
    a_nmi_code: assert property (s_nmi_won |=> event_q == 12'h1c0)
        else $error("nmi event code wrong");
    a_above_mask: assert property (core_q.req && core_q.level != 5'h10
        |-> $past(win_level) > {1'b0, $past(core_in.current_mask_level)})
        else $error("request not above current mask level");
    a_mask_clears_held: assert property (mask_wr_ones[7:0] != 8'h00
        |=> (held_q & $past(mask_wr_ones[7:0]) & ~$past(pin_set)) == 8'h00)
        else $error("mask write did not clear held request");
    a_edge_latched: assert property ((sense_q & pin_stab_q & ~pin_prev_q) != 8'h00
        |=> (held_q & $past(sense_q & pin_stab_q & ~pin_prev_q)) != 8'h00)
        else $error("pin edge not latched");
endmodule

// *** verification/pic_core_model.sv ***
// processor core partner: takes presented requests, tracks its mask level.
// assumes the controller's core ports, on the same clock and reset.
`timescale 1ns/1ps
module pic_core_model (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   blk,
    input  wire logic                   lp,
    input  wire logic                   usr,
    input  wire logic                   take,
    input  wire logic                   mset,
    input  wire logic [3:0]             mval,
    input  wire pic_pkg::pic_core_out_t core_out,
    output pic_pkg::pic_core_in_t       core_in,
    output logic                        core_accept
);
    logic [3:0] mask_q;
    logic [1:0] gap_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= 4'h0;
        end else if (mset) begin
            mask_q <= mval;
        end else if (core_out.mask_load) begin
            mask_q <= core_out.mask_value;
        end
    end

    // one accept, then a pause so the stale request is not taken twice
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_accept <= 1'h0;
            gap_q       <= 2'h0;
        end else begin
            core_accept <= take && core_out.req && gap_q == 2'h0 && !core_accept;
            gap_q       <= core_accept ? 2'h3 : (gap_q != 2'h0 ? gap_q - 2'h1 : 2'h0);
        end
    end

    assign core_in = {blk, lp, usr, mask_q};
endmodule

// *** verification/priority_interrupt_controller_bench.sv ***
// self-checking bench: apb master, request pins, nmi and a core partner.
// assumes pic_top and pic_core_model; one 40 MHz clock.
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
    logic                   clk;
    logic                   arst_n;
    logic                   psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]             paddr, irq_pins, periph_req;
    logic [31:0]            pwdata, prdata, rd;
    logic                   nmi_pin, blk, lp, usr, take, mset, core_accept;
    logic [3:0]             mval;
    logic [11:0]            event_code;
    pic_pkg::pic_core_in_t  core_in;
    pic_pkg::pic_core_out_t core_out;
    int                     bad_count, checked, seed, n;
    logic [31:0]            lvl;

    pic_top uut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .irq_pins(irq_pins), .periph_req(periph_req),
        .core_in(core_in), .core_accept(core_accept), .core_out(core_out),
        .event_code(event_code));
    pic_core_model core (.clk(clk), .arst_n(arst_n), .blk(blk), .lp(lp), .usr(usr),
        .take(take), .mset(mset), .mval(mval), .core_out(core_out), .core_in(core_in),
        .core_accept(core_accept));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("counts: %0d checked, %0d bad", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (k >= 20) chk(32'h0000_0000, 32'h0000_0001);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask

    // priorities change only with the block bit set, then one read of the pin priority register
    task automatic prog(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = blk;
        blk <= 1'h1;
        apb(1'h1, a, d);
        apb(1'h0, pic_pkg::OFF_PIN_PRIO, 32'h0000_0000);
        blk <= b;
    endtask

    task automatic quiet();
        repeat (12) @(posedge clk);
        chk({31'h0, core_out.req}, 32'h0000_0000);
    endtask

    task automatic setmask(input logic [3:0] v);
        mset <= 1'h1;
        mval <= v;
        @(posedge clk);
        mset <= 1'h0;
        @(posedge clk);
    endtask

    task automatic take_one(input logic [31:0] code, input logic [31:0] l);
        int k;
        k = 0;
        while (core_out.req !== 1'h1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        chk({27'h0, core_out.level}, l);
        take <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (core_accept !== 1'h1 && k < 80);
        take <= 1'h0;
        irq_pins <= 8'h00;
        repeat (2) @(posedge clk);
        chk({20'h0, event_code}, code);
        $display("test accept %h done", code);
    endtask

    initial begin
        clk = 1'h0;
        arst_n = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {irq_pins, periph_req, blk, lp, usr, take, mset, mval} = '0;
        nmi_pin = 1'h1;
        bad_count = 0;
        checked = 0;
        seed = 32'ha53f;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        @(posedge clk);
        rdc(pic_pkg::OFF_PIN_PRIO, 32'h0000_0000, 1'h0);
        rdc(pic_pkg::OFF_MOD_FIRST, 32'h0000_0000, 1'h0);
        rdc(pic_pkg::OFF_MOD_LAST, 32'h0000_0000, 1'h0);
        rdc(8'h28, 32'h0000_0000, 1'h1);
        irq_pins <= 8'h01;
        quiet();
        irq_pins <= 8'h00;
        apb(1'h1, pic_pkg::OFF_MASK_SET, 32'h0000_0001);
        apb(1'h1, pic_pkg::OFF_MASK_CLR, 32'h0000_0001);
        $display("test reset done");
        for (n = 0; n < 8; n++) begin
            lvl = 32'h0000_0001 + ($unsigned($random(seed)) % 15);
            prog(pic_pkg::OFF_PIN_PRIO, lvl << (28 - 4 * n));
            irq_pins[n] <= 1'h1;
            take_one(pic_pkg::CODE_PIN_BASE + pic_pkg::CODE_STEP * n, lvl);
        end
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0005_0050);
        prog(pic_pkg::OFF_MOD_FIRST, 32'h0000_0005);
        irq_pins <= 8'h48;
        blk <= 1'h1;
        periph_req <= 8'h01;
        repeat (8) @(posedge clk);
        blk <= 1'h0;
        take_one(32'h0000_0660, 32'h0000_0005);
        take_one(32'h0000_06c0, 32'h0000_0005);
        take_one(32'h0000_0700, 32'h0000_0005);
        periph_req <= 8'h00;
        apb(1'h1, pic_pkg::OFF_OPMODE, 32'h0000_0001);
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0990_0000);
        irq_pins <= 8'h04;
        take_one(32'h0000_0640, 32'h0000_0009);
        chk({28'h0, core_in.current_mask_level}, 32'h0000_0009);
        irq_pins <= 8'h02;
        quiet();
        setmask(4'h0);
        take_one(32'h0000_0620, 32'h0000_0009);
        setmask(4'h3);
        blk <= 1'h1;
        nmi_pin <= 1'h0;
        quiet();
        lp <= 1'h1;
        take_one({20'h0, pic_pkg::CODE_NMI}, 32'h0000_0010);
        chk({28'h0, core_in.current_mask_level}, 32'h0000_0003);
        lp <= 1'h0;
        nmi_pin <= 1'h1;
        apb(1'h1, pic_pkg::OFF_CTRL_ZERO, 32'h0000_0002);
        nmi_pin <= 1'h0;
        take_one({20'h0, pic_pkg::CODE_NMI}, 32'h0000_0010);
        nmi_pin <= 1'h1;
        quiet();
        apb(1'h1, pic_pkg::OFF_CTRL_ZERO, 32'h0000_0003);
        nmi_pin <= 1'h0;
        repeat (6) @(posedge clk);
        nmi_pin <= 1'h1;
        take_one({20'h0, pic_pkg::CODE_NMI}, 32'h0000_0010);
        blk <= 1'h0;
        apb(1'h1, pic_pkg::OFF_OPMODE, 32'h0000_0000);
        setmask(4'h0);
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0000_6000);
        irq_pins <= 8'h10;
        repeat (12) @(posedge clk);
        chk({31'h0, core_out.req}, 32'h0000_0001);
        irq_pins <= 8'h00;
        repeat (10) @(posedge clk);
        chk({31'h0, core_out.req}, 32'h0000_0001);
        apb(1'h1, pic_pkg::OFF_MASK_SET, 32'h0000_0010);
        apb(1'h1, pic_pkg::OFF_MASK_CLR, 32'h0000_0010);
        quiet();
        apb(1'h1, pic_pkg::OFF_CTRL_ONE, 32'h0000_0020);
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0000_0400);
        irq_pins <= 8'h20;
        repeat (3) @(posedge clk);
        irq_pins <= 8'h00;
        repeat (10) @(posedge clk);
        take_one(32'h0000_06a0, 32'h0000_0004);
        usr <= 1'h1;
        apb(1'h1, pic_pkg::OFF_USER_MASK, 32'h0000_0007);
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0000_0007);
        irq_pins <= 8'h80;
        quiet();
        prog(pic_pkg::OFF_PIN_PRIO, 32'h0000_0008);
        irq_pins <= 8'h80;
        take_one(32'h0000_06e0, 32'h0000_0008);
        print_verdict();
    end

    // cut a hang short
    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end
endmodule
